// ==== shared/tpd_map.svh ====
// Constants for the three-phase gate input decoder.
// Assumes inclusion by both ends, not the interface; definitions only.
`ifndef TPD_MAP_SVH
`define TPD_MAP_SVH
`define TPD_SCHEME_SIX 2'h0
`define TPD_SCHEME_THREE 2'h1
`define TPD_SCHEME_SINGLE 2'h2
`define TPD_SCHEME_INDEP 2'h3
`define TPD_CODE_STOP 3'h0
`define TPD_CODE_ALIGN 3'h7
`define TPD_CODE_BC 3'h6
`define TPD_CODE_AC 3'h4
`define TPD_CODE_AB 3'h5
`define TPD_CODE_CB 3'h1
`define TPD_CODE_CA 3'h3
`define TPD_CODE_BA 3'h2
`define TPD_PHASE_A 0
`define TPD_PHASE_B 1
`define TPD_PHASE_C 2
`define TPD_REG_SCHEME 2'h0
`define TPD_REG_FREEWHEEL 2'h1
`define TPD_REG_CMD 2'h2
`define TPD_REG_GATES 2'h3
`endif

// ==== shared/tpd_pkg.sv ====
// Types shared by both ends of the gate input decoder link.
// Assumes tpd_map.svh supplies the numeric constants.
package tpd_pkg;
	typedef logic [1:0] tpd_scheme_t;
	typedef logic [2:0] tpd_phase_t;
endpackage

// ==== shared/tpd_link_if.sv ====
// Link between the motor controller and the gate input decoder.
// Assumes one clock domain owned by the testbench.
`timescale 1ns/100ps
interface tpd_link_if;
	tpd_pkg::tpd_phase_t high_side_command;
	tpd_pkg::tpd_phase_t low_side_command;
	tpd_pkg::tpd_scheme_t scheme_select;
	logic freewheel_style_select;
	modport device (
		input high_side_command,
		input low_side_command,
		input scheme_select,
		input freewheel_style_select
	);
	modport controller (
		output high_side_command,
		output low_side_command,
		output scheme_select,
		output freewheel_style_select
	);
endinterface

// ==== core/tpd_decoder.sv ====
// What this block does
// RL1: Scheme 00b selects six-input decoding
// RL2: Six-input: lone command drives its gate
// RL3: Scheme 01b selects three-input decoding
// RL4: Three-input: low command zero floats phase
// RL5: Three-input: high command picks upper/lower gate
// RL6: Controller holds low commands high if unused
// RL7: Scheme 10b selects single-PWM commutation
// RL8: Phase A high command carries PWM
// RL9: Three inputs form commutation state code
// RL10: Six codes select source and sink phases
// RL11: Direction one inverts the state code
// RL12: Code zero stops, code seven aligns
// RL13: Synchronous freewheel: lower gate gets inverse PWM
// RL14: Asynchronous freewheel: lower PWM gate stays off
// RL15: Brake low forces all lower gates on
// RL16: Controller holds direction low, brake high
// RL17: Scheme 11b selects independent control
// RL18: Independent: each gate follows own command
// RL19: Controller never commands both gates together
// RL20: Split loads need sense rewiring, monitors off
// RL21: Commands low before changing scheme; the controller zeroes them in the same cycle as the scheme write
// RL22: Gates registered from synced inputs, off in reset
//
// Device end: decodes the six commands into six gate enables.
// Assumes inputs may be asynchronous; all are synchronised here.
`timescale 1ns/100ps
`include "tpd_map.svh"
module tpd_decoder (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Controller link
	tpd_link_if.device link,
	// Gate enables, bit 0 is phase A
	output logic [2:0] o_upper_gate_output,
	output logic [2:0] o_lower_gate_output,
	// Scheme in force
	output logic [1:0] o_scheme
);
	localparam int NIN = 9;
	logic [NIN-1:0] sync_a;
	logic [NIN-1:0] sync_b;
	logic [2:0] hi;
	logic [2:0] lo;
	tpd_pkg::tpd_scheme_t scheme;
	logic freewheel_async;
	logic [2:0] code;
	logic pwm;
	logic dir;
	logic brake_n;
	logic [2:0] src;
	logic [2:0] sink;
	logic [2:0] next_upper;
	logic [2:0] next_lower;

	// Two flops before any logic reads the pins
	always_ff @(posedge i_clock or negedge i_arst_n) begin // see RL22
		if (!i_arst_n) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {link.freewheel_style_select, link.scheme_select,
				link.low_side_command, link.high_side_command};
			sync_b <= sync_a;
		end
	end

	assign hi = sync_b[2:0];
	assign lo = sync_b[5:3];
	assign scheme = sync_b[7:6];
	assign freewheel_async = sync_b[8];
	assign pwm = hi[`TPD_PHASE_A]; // see RL8
	assign code = {lo[`TPD_PHASE_A], hi[`TPD_PHASE_B],
		lo[`TPD_PHASE_B]}; // see RL9
	assign dir = hi[`TPD_PHASE_C];
	assign brake_n = lo[`TPD_PHASE_C];

	// Source and sink phases of each commutation step
	always_comb begin
		logic [2:0] c;
		c = code;
		// Stop and align ignore direction; only the six steps flip
		if (dir && code != `TPD_CODE_STOP &&
			code != `TPD_CODE_ALIGN) begin
			c = ~code; // see RL11
		end
		src = 3'h0;
		sink = 3'h0;
		case (c) // see RL10
			`TPD_CODE_BC: begin
				src = 3'h2;
				sink = 3'h4;
			end
			`TPD_CODE_AC: begin
				src = 3'h1;
				sink = 3'h4;
			end
			`TPD_CODE_AB: begin
				src = 3'h1;
				sink = 3'h2;
			end
			`TPD_CODE_CB: begin
				src = 3'h4;
				sink = 3'h2;
			end
			`TPD_CODE_CA: begin
				src = 3'h4;
				sink = 3'h1;
			end
			`TPD_CODE_BA: begin
				src = 3'h2;
				sink = 3'h1;
			end
			`TPD_CODE_ALIGN: begin // see RL12
				src = 3'h1;
				sink = 3'h6;
			end
			default: begin // see RL12
				src = 3'h0;
				sink = 3'h0;
			end
		endcase
	end

	always_comb begin
		next_upper = 3'h0;
		next_lower = 3'h0;
		case (scheme)
			`TPD_SCHEME_SIX: begin // see RL1
				next_upper = hi & ~lo; // see RL2
				next_lower = lo & ~hi; // see RL2
			end
			`TPD_SCHEME_THREE: begin // see RL3
				next_upper = lo & hi; // see RL4
				next_lower = lo & ~hi; // see RL5
			end
			`TPD_SCHEME_SINGLE: begin // see RL7
				if (!brake_n) begin
					next_upper = 3'h0; // see RL15
					next_lower = 3'h7; // see RL15
				end else begin
					next_upper = pwm ? src : 3'h0;
					// Async style lets the body diode freewheel
					next_lower = sink | ((freewheel_async || pwm) ?
						3'h0 : src); // see RL13 see RL14
				end
			end
			`TPD_SCHEME_INDEP: begin // see RL17
				// No interlock: shoot-through is the user's to avoid
				next_upper = hi; // see RL18
				next_lower = lo; // see RL18
			end
			default: begin
				next_upper = 3'h0;
				next_lower = 3'h0;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin // see RL22
		if (!i_arst_n) begin
			o_upper_gate_output <= 3'h0;
			o_lower_gate_output <= 3'h0;
			o_scheme <= `TPD_SCHEME_SIX;
		end else begin
			o_upper_gate_output <= next_upper;
			o_lower_gate_output <= next_lower;
			o_scheme <= scheme;
		end
	end
endmodule

// ==== core/tpd_controller.sv ====
// Controller end: drives the decoder link from a small register port.
// Assumes software on the same clock; read data one cycle later.
`timescale 1ns/100ps
`include "tpd_map.svh"
module tpd_controller (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Software port
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [7:0] o_rdata,
	// Gate state seen from the decoder
	input wire logic [2:0] i_upper_gate_output,
	input wire logic [2:0] i_lower_gate_output,
	// Decoder link
	tpd_link_if.controller link
);
	tpd_pkg::tpd_scheme_t scheme;
	logic freewheel;
	tpd_pkg::tpd_phase_t high_cmd;
	tpd_pkg::tpd_phase_t low_cmd;
	logic [2:0] up_s1;
	logic [2:0] up_s2;
	logic [2:0] lo_s1;
	logic [2:0] lo_s2;

	// Scheme write forces all commands low in the same cycle, so no glitchy step
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			scheme <= `TPD_SCHEME_SIX;
			freewheel <= 1'b0;
			high_cmd <= 3'h0;
			low_cmd <= 3'h0;
		end else if (i_write) begin
			case (i_addr)
				`TPD_REG_SCHEME: begin
					scheme <= i_wdata[1:0];
					high_cmd <= 3'h0; // see RL21
					low_cmd <= 3'h0; // see RL21
				end
				`TPD_REG_FREEWHEEL: begin
					freewheel <= i_wdata[0];
				end
				`TPD_REG_CMD: begin
					// Software owns RL6, RL16, RL19 command choices
					high_cmd <= i_wdata[2:0];
					low_cmd <= i_wdata[5:3];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			up_s1 <= 3'h0;
			up_s2 <= 3'h0;
			lo_s1 <= 3'h0;
			lo_s2 <= 3'h0;
		end else begin
			up_s1 <= i_upper_gate_output;
			up_s2 <= up_s1;
			lo_s1 <= i_lower_gate_output;
			lo_s2 <= lo_s1;
		end
	end

	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 8'h00;
		end else if (i_read) begin
			case (i_addr)
				`TPD_REG_SCHEME: o_rdata <= {6'h00, scheme};
				`TPD_REG_FREEWHEEL: o_rdata <= {7'h00, freewheel};
				`TPD_REG_CMD: o_rdata <= {2'h0, low_cmd, high_cmd};
				default: o_rdata <= {2'h0, lo_s2, up_s2};
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	assign link.scheme_select = scheme;
	assign link.freewheel_style_select = freewheel;
	assign link.high_side_command = high_cmd;
	assign link.low_side_command = low_cmd;
endmodule

// ==== testbench/tpd_checker.sv ====
// Checks the decoder gates against the link three edges earlier.
// Assumes one clock and the testbench wiring it beside the link.
`timescale 1ns/100ps
module tpd_checker (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Link and gates
	input wire logic [2:0] high_side_command,
	input wire logic [2:0] low_side_command,
	input wire logic [1:0] scheme_select,
	input wire logic freewheel_style_select,
	input wire logic [2:0] o_upper_gate_output,
	input wire logic [2:0] o_lower_gate_output
);
	logic [26:0] p;
	logic [1:0] s;
	logic f;
	logic [2:0] h, l, c, u, w, q;
	assign {s, f, h, l} = p[26:18];
	assign q = {l[0], h[1], l[1]};
	// Direction flips the six steps but never stop or align
	assign c = (q == 3'h0 || q == 3'h7) ? q : q ^ {3{h[2]}};
	assign u = o_upper_gate_output;
	assign w = o_lower_gate_output;
	// Mirrors two sync flops and the output register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			p <= 27'h0;
		else
			p <= {p[17:0], scheme_select, freewheel_style_select,
				high_side_command, low_side_command};
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	a_six_pair: assert property (s == 2'h0 |->
		u == (h & ~l) && w == (l & ~h)) else $error("six bad");
	a_three_float: assert property (s == 2'h1 |->
		u == (l & h) && w == (l & ~h)) else $error("three bad");
	a_indep_follow: assert property (s == 2'h3 |->
		u == h && w == l) else $error("indep bad");
	a_brake_all: assert property (s == 2'h2 && !l[2] |->
		u == 3'h0 && w == 3'h7) else $error("brake bad");
	a_stop_off: assert property (s == 2'h2 && l[2] && q == 3'h0 |->
		u == 3'h0 && w == 3'h0) else $error("stop bad");
	a_align_pwm: assert property (s == 2'h2 && l[2] && q == 3'h7 |->
		u == {2'h0, h[0]} && w == {2'h3, ~h[0] & ~f}) else $error("align");
	a_step_bc: assert property (s == 2'h2 && l[2] && c == 3'h6 |->
		u == {1'h0, h[0], 1'h0} && w == {1'h1, ~h[0] & ~f, 1'h0})
		else $error("step bad");
	a_reset_clear: assert property ($rose(i_arst_n) |->
		(u == 3'h0 && w == 3'h0) [*3]) else $error("reset bad");
	c_align: cover property (s == 2'h2 && l[2] && c == 3'h7);
	c_float: cover property (s == 2'h1 && l == 3'h0);
	c_both: cover property (s == 2'h3 && (h & l) == 3'h7);
endmodule

// ==== testbench/tpd_test.sv ====
// Bench: register port drives the controller, decoder gates compared.
// Assumes both ends share one 25 MHz clock.
`timescale 1ns/100ps
module tpd_test;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_write = 1'b0;
	logic i_read = 1'b0;
	logic [7:0] o_rdata;
	logic [2:0] up, lo;
	logic [1:0] sch;
	int errors = 0;
	int checks = 0;
	tpd_link_if i_link ();
	tpd_decoder i_tpd_decoder (.i_clock, .i_arst_n, .link(i_link.device),
		.o_upper_gate_output(up), .o_lower_gate_output(lo), .o_scheme(sch));
	tpd_controller i_tpd_controller (.i_clock, .i_arst_n, .i_addr,
		.i_wdata, .i_write, .i_read, .o_rdata, .i_upper_gate_output(up),
		.i_lower_gate_output(lo), .link(i_link.controller));
	tpd_checker i_tpd_checker (.i_clock, .i_arst_n,
		.high_side_command(i_link.high_side_command),
		.low_side_command(i_link.low_side_command),
		.scheme_select(i_link.scheme_select),
		.freewheel_style_select(i_link.freewheel_style_select),
		.o_upper_gate_output(up), .o_lower_gate_output(lo));
	always #20 i_clock = ~i_clock;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask
	// Leaves time 1ns into the only cycle holding read data
	task rd(input logic [1:0] a);
		@(posedge i_clock);
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1;
	endtask
	// Commutation tables packed three bits per state code
	function automatic logic [7:0] m(input logic [1:0] s,
		input logic f, input logic [5:0] e);
		logic [2:0] h, l, c, a, k, u, w;
		h = e[2:0];
		l = e[5:3];
		c = {l[0], h[1], l[1]};
		if (c != 3'h0 && c != 3'h7)
			c = c ^ {3{h[2]}};
		a = 3'(24'h2898a0 >> (3 * c));
		k = 3'(24'hd14250 >> (3 * c));
		case (s)
			2'h0: {w, u} = {l & ~h, h & ~l};
			2'h1: {w, u} = {l & ~h, l & h};
			2'h2: {w, u} = {k | (a & {3{~h[0] & ~f}}), a & {3{h[0]}}};
			default: {w, u} = {l, h};
		endcase
		if (s == 2'h2 && !l[2])
			{w, u} = 6'h38;
		return {2'h0, w, u};
	endfunction
	task stop_test;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		logic [7:0] r;
		logic [7:0] x;
		logic [5:0] e;
		r = 8'($urandom(18983));
		repeat (5) @(posedge i_clock);
		i_arst_n <= 1'b1;
		#1 chk({2'h0, lo, up}, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr(2'h0, {6'h0, k[2:1]});
			wr(2'h1, {7'h0, k[0]});
			rd(2'h0);
			chk(o_rdata, {6'h0, k[2:1]});
			r = 8'($urandom);
			for (int i = 0; i < 64; i++) begin
				e = i[5:0] ^ r[5:0];
				x = m(k[2:1], k[0], e);
				wr(2'h2, {r[7:6], e});
				repeat (6) @(posedge i_clock);
				#1 chk({2'h0, lo, up}, x);
				wr(2'h3, r);
				rd(2'h3);
				chk(o_rdata, x);
			end
			chk({6'h0, sch}, {6'h0, k[2:1]});
			$display("scheme %0d freewheel %0d done", k[2:1], k[0]);
		end
		// Recommended controller habits, one per scheme 01b to 11b
		wr(2'h1, 8'h00);
		for (int j = 1; j < 4; j++) begin
			r = 8'($urandom);
			case (j)
				1: e = {3'h7, r[2:0]};
				2: e = {1'b1, r[4:3], 1'b0, r[1:0]};
				default: e = {~r[2:0] & r[5:3], r[2:0]};
			endcase
			wr(2'h0, {6'h0, j[1:0]});
			wr(2'h2, {2'h0, e});
			repeat (6) @(posedge i_clock);
			#1 chk({2'h0, lo, up}, m(j[1:0], 1'b0, e));
			chk({5'h00, up & lo}, 8'h00);
			$display("habit %0d done", j);
		end
		stop_test();
	end
endmodule
